// file: hw/idc_pkg.sv
// constants, layouts and types of the dma channel control registers
//
// Contract
// RL1 - high status: requests 6,5; counts 7,6,5
// RL2 - high status bits 4 and 0 read zero
// RL3 - request port: bit 2 value, bits 1:0 channel
// RL4 - single mask port: bit 2 masks chosen channel
// RL5 - mode port stores type, autoinit, direction, mode
// RL6 - mode 10 selects block, 11 cascade
// RL7 - direction bit 1 decrements, 0 increments address
// RL8 - pointer-clear write resets byte pointer
// RL9 - full-reset write restores controller reset state
// RL10 - unmask-all write clears all channel masks
// RL11 - all-mask port loads four masks; reset masked
// RL12 - page registers give address 23:16, reset zero
// RL13 - software avoids reserved page addresses
// RL14 - extended mode stores channel select, timing
// RL15 - byte pointer toggles on each address/count access
// RL16 - mask 1 blocks service, 0 re-enables
// RL17 - software request acts like peripheral request
// RL18 - status read only clears latched counts
package idc_pkg;
  // ---------------------------------------------------------------
  // io offsets, index 0 low controller, index 1 high controller
  // ---------------------------------------------------------------
  localparam logic [1:0][15:0] OFS_REQ     = {16'h00D2, 16'h0009};
  localparam logic [1:0][15:0] OFS_MASK    = {16'h00D4, 16'h000A};
  localparam logic [1:0][15:0] OFS_MODE    = {16'h00D6, 16'h000B};
  localparam logic [1:0][15:0] OFS_PTR     = {16'h00D8, 16'h000C};
  localparam logic [1:0][15:0] OFS_CLR     = {16'h00DA, 16'h000D};
  localparam logic [1:0][15:0] OFS_UNMASK  = {16'h00DC, 16'h000E};
  localparam logic [1:0][15:0] OFS_ALLMASK = {16'h00DE, 16'h000F};
  localparam logic [1:0][15:0] OFS_EXT     = {16'h04D6, 16'h040B};
  localparam logic [1:0][15:0] WIN_LO      = {16'h00C0, 16'h0000};
  localparam logic [1:0][15:0] WIN_HI      = {16'h00CF, 16'h0007};
  localparam logic [15:0]      OFS_HI_STATUS = 16'h00D0;
  // pages per channel 7..0; channels 0 and 4 have none here
  localparam logic [7:0][15:0] OFS_PAGE = {16'h008A, 16'h0089,
    16'h008B, 16'h0000, 16'h0082, 16'h0081, 16'h0083, 16'h0000};
  localparam logic [7:0]       PAGE_MAP = 8'hEE;
  // ---------------------------------------------------------------
  // field positions and encodings
  // ---------------------------------------------------------------
  localparam int unsigned VAL_BIT     = 2;
  localparam int unsigned TYPE_LSB    = 2;
  localparam int unsigned AUTO_BIT    = 4;
  localparam int unsigned DEC_BIT     = 5;
  localparam int unsigned XMODE_LSB   = 6;
  localparam int unsigned TIM_LSB     = 4;
  localparam logic [1:0]  XMODE_BLOCK = 2'h2;
  localparam logic [1:0]  XMODE_CASC  = 2'h3;
  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [3:0]  MASK_RST    = 4'hF;
  localparam logic [7:0]  PAGE_RST    = 8'h00;
  localparam logic [1:0]  TIM_RST     = 2'h0;
  localparam logic        RDY_RST     = 1'b1;
  localparam int unsigned FIFO_DEPTH  = 16;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
  } idc_cmd_s;
  typedef struct packed {
    logic [1:0] xfer_mode;
    logic       addr_dec;
    logic       auto_init;
    logic [1:0] xfer_type;
  } idc_mode_s;
  localparam idc_mode_s MODE_RST = '0;
endpackage : idc_pkg

// file: hw/idc_top.sv
// dma channel control registers with write command fifo
`timescale 1ns/1ps

// ---------------------------------------------------------------
// generic fifo, depth must be a power of two
// ---------------------------------------------------------------
module idc_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // fill side
  input  wire logic                     in_valid_i,
  output logic                          in_ready_o,
  input  wire logic [W-1:0]             in_data_i,
  // drain side
  output logic                          out_valid_o,
  input  wire logic                     out_ready_i,
  output logic [W-1:0]                  out_data_o,
  output logic [$clog2(DEPTH):0]        count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o  = mem_q[rp_q];
  assign count_o     = cnt_q;
  assign push        = in_valid_i && in_ready_o && ce_i;
  assign pop         = out_valid_o && out_ready_i && ce_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_q + AW'(push);
      rp_q  <= rp_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : idc_fifo

// ---------------------------------------------------------------
// control registers of both controllers
// ---------------------------------------------------------------
module idc_top #(
  parameter int DEPTH = idc_pkg::FIFO_DEPTH
) (
  // clock, reset, enable
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     ce_i,
  // io cycles from the host
  input  wire logic [15:0]              io_addr_i,
  input  wire logic [7:0]               io_wdata_i,
  input  wire logic                     io_wr_i,
  input  wire logic                     io_rd_i,
  output logic                          io_wr_rdy_o,
  output logic                          io_rd_rdy_o,
  output logic [7:0]                    io_rdata_o,
  output logic                          io_rvalid_o,
  // peripheral request pins
  input  wire logic [7:0]               dreq_pin_i,
  // transfer engine side
  input  wire logic [7:0]               tc_evt_i,
  input  wire logic                     cmd_hold_i,
  output logic [7:0]                    svc_req_o,
  output idc_pkg::idc_mode_s [7:0]      chan_mode_o,
  output logic [7:0]                    block_mode_o,
  output logic [7:0]                    cascade_o,
  output logic [7:0]                    addr_down_o,
  output logic [7:0][7:0]               page_o,
  output logic [7:0][1:0]               ext_timing_o,
  output logic [1:0]                    byte_ptr_o
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ---------------------------------------------------------------
  // state and decode signals
  // ---------------------------------------------------------------
  idc_pkg::idc_cmd_s        push_cmd;
  idc_pkg::idc_cmd_s        cmd;
  idc_pkg::idc_mode_s [7:0] mode_q;
  logic                     cmd_valid;
  logic [CW-1:0]            fifo_cnt;
  logic [CW-1:0]            cnt_nx;
  logic                     push;
  logic                     pop;
  logic                     rd_take;
  logic                     st_rd;
  logic [1:0]               cmd_sel;
  logic                     cmd_bit;
  logic [7:0]               dreq_s1_q;
  logic [7:0]               dreq_s2_q;
  logic [7:0]               sw_req_q;
  logic [7:0]               mask_q;
  logic [7:0]               tc_q;
  logic [7:0]               raw_req;
  logic [7:0][7:0]          page_q;
  logic [7:0][1:0]          tim_q;
  logic [1:0]               ptr_q;
  logic [1:0]               d_req;
  logic [1:0]               d_mask;
  logic [1:0]               d_mode;
  logic [1:0]               d_ptr;
  logic [1:0]               d_clr;
  logic [1:0]               d_unmask;
  logic [1:0]               d_allmask;
  logic [1:0]               d_ext;
  logic [1:0]               d_tog;
  logic [7:0]               d_page;
  logic [7:0]               status_byte;
  logic [7:0]               rd_mux;
  logic                     wr_rdy_q;
  logic                     rd_rdy_q;
  logic                     rvalid_q;
  logic [7:0]               rdata_q;
  logic [7:0]               svc_q;
  logic [7:0]               block_q;
  logic [7:0]               casc_q;
  logic [7:0]               down_q;

  // ---------------------------------------------------------------
  // write command fifo
  // ---------------------------------------------------------------
  // writes are queued so the host waits on a held engine only once DEPTH-1 writes are queued;
  // reads wait for the queue to drain so they see every write
  assign push          = io_wr_i && wr_rdy_q && ce_i;
  assign push_cmd.addr = io_addr_i;
  assign push_cmd.data = io_wdata_i;
  assign pop           = cmd_valid && !cmd_hold_i && ce_i;
  assign rd_take       = io_rd_i && rd_rdy_q && ce_i;
  assign cmd_sel       = cmd.data[1:0];
  assign cmd_bit       = cmd.data[idc_pkg::VAL_BIT];
  assign cnt_nx        = fifo_cnt + CW'(push) - CW'(pop);
  assign st_rd         = rd_take && (io_addr_i == idc_pkg::OFS_HI_STATUS);

  idc_fifo #(
    .W     ($bits(idc_pkg::idc_cmd_s)),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (push),
    .in_ready_o  (),
    .in_data_i   (push_cmd),
    .out_valid_o (cmd_valid),
    .out_ready_i (!cmd_hold_i),
    .out_data_o  (cmd),
    .count_o     (fifo_cnt)
  );

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      wr_rdy_q <= idc_pkg::RDY_RST;
      rd_rdy_q <= idc_pkg::RDY_RST;
    end else if (ce_i) begin
      wr_rdy_q <= cnt_nx <= CW'(DEPTH - 2);
      rd_rdy_q <= cnt_nx == '0;
    end
  end

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      d_req[c]     = pop && (cmd.addr == idc_pkg::OFS_REQ[c]);
      d_mask[c]    = pop && (cmd.addr == idc_pkg::OFS_MASK[c]);
      d_mode[c]    = pop && (cmd.addr == idc_pkg::OFS_MODE[c]);
      d_ptr[c]     = pop && (cmd.addr == idc_pkg::OFS_PTR[c]);
      d_clr[c]     = pop && (cmd.addr == idc_pkg::OFS_CLR[c]);
      d_unmask[c]  = pop && (cmd.addr == idc_pkg::OFS_UNMASK[c]);
      d_allmask[c] = pop && (cmd.addr == idc_pkg::OFS_ALLMASK[c]);
      d_ext[c]     = pop && (cmd.addr == idc_pkg::OFS_EXT[c]);
      d_tog[c]     = (pop && cmd.addr >= idc_pkg::WIN_LO[c]
                      && cmd.addr <= idc_pkg::WIN_HI[c])
                  || (rd_take && io_addr_i >= idc_pkg::WIN_LO[c]
                      && io_addr_i <= idc_pkg::WIN_HI[c]);
    end
    for (int k = 0; k < 8; k++) begin
      d_page[k] = pop && idc_pkg::PAGE_MAP[k]
               && (cmd.addr == idc_pkg::OFS_PAGE[k]);
    end
  end

  // ---------------------------------------------------------------
  // requests
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      dreq_s1_q <= '0;
      dreq_s2_q <= '0;
    end else if (ce_i) begin
      dreq_s1_q <= dreq_pin_i;
      dreq_s2_q <= dreq_s1_q;
    end
  end

  // a software request is dropped by its channel's terminal count
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sw_req_q <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (d_clr[c]) begin
          sw_req_q[c*4 +: 4] <= '0; // RL9
        end else begin
          for (int j = 0; j < 4; j++) begin
            if (tc_evt_i[c*4+j]) begin
              sw_req_q[c*4+j] <= 1'b0;
            end
          end
          if (d_req[c]) begin
            sw_req_q[{1'(c), cmd_sel}] <= cmd_bit; // RL3 RL17
          end
        end
      end
    end
  end

  assign raw_req = dreq_s2_q | sw_req_q; // RL17

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      svc_q <= '0;
    end else if (ce_i) begin
      svc_q <= raw_req & ~mask_q; // RL16
    end
  end

  // ---------------------------------------------------------------
  // masks
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mask_q <= {idc_pkg::MASK_RST, idc_pkg::MASK_RST}; // RL11
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (d_clr[c]) begin
          mask_q[c*4 +: 4] <= idc_pkg::MASK_RST; // RL9
        end else if (d_unmask[c]) begin
          mask_q[c*4 +: 4] <= '0; // RL10
        end else if (d_allmask[c]) begin
          mask_q[c*4 +: 4] <= cmd.data[3:0]; // RL11
        end else if (d_mask[c]) begin
          mask_q[{1'(c), cmd_sel}] <= cmd_bit; // RL4 RL16
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // terminal count flags
  // ---------------------------------------------------------------
  // set wins over a clear in the same cycle, so no count is lost
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tc_q <= '0;
    end else if (ce_i) begin
      tc_q <= (tc_q & ~{{4{d_clr[1] | st_rd}}, {4{d_clr[0]}}})
            | tc_evt_i; // RL18
    end
  end

  // ---------------------------------------------------------------
  // modes and extended timing
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mode_q <= {8{idc_pkg::MODE_RST}};
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (d_clr[c]) begin
          mode_q[c*4 +: 4] <= {4{idc_pkg::MODE_RST}};
        end else if (d_mode[c]) begin
          mode_q[{1'(c), cmd_sel}] <= '{ // RL5
            xfer_mode: cmd.data[idc_pkg::XMODE_LSB +: 2],
            addr_dec:  cmd.data[idc_pkg::DEC_BIT],
            auto_init: cmd.data[idc_pkg::AUTO_BIT],
            xfer_type: cmd.data[idc_pkg::TYPE_LSB +: 2]};
        end
      end
    end
  end

  // high controller select 0 is its cascade link and is ignored
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      tim_q <= {8{idc_pkg::TIM_RST}};
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (d_clr[c]) begin
          tim_q[c*4 +: 4] <= {4{idc_pkg::TIM_RST}};
        end else if (d_ext[c] && !(c == 1 && cmd_sel == 2'h0)) begin
          tim_q[{1'(c), cmd_sel}] <= cmd.data[idc_pkg::TIM_LSB +: 2]; // RL14
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      block_q <= '0;
      casc_q  <= '0;
      down_q  <= '0;
    end else if (ce_i) begin
      for (int k = 0; k < 8; k++) begin
        block_q[k] <= mode_q[k].xfer_mode == idc_pkg::XMODE_BLOCK; // RL6
        casc_q[k]  <= mode_q[k].xfer_mode == idc_pkg::XMODE_CASC; // RL6
        down_q[k]  <= mode_q[k].addr_dec; // RL7
      end
    end
  end

  // ---------------------------------------------------------------
  // pages and byte pointers
  // ---------------------------------------------------------------
  // page registers survive a full reset of either controller
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      page_q <= {8{idc_pkg::PAGE_RST}}; // RL12
    end else if (ce_i) begin
      for (int k = 0; k < 8; k++) begin
        if (d_page[k]) begin
          page_q[k] <= cmd.data; // RL12
        end
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ptr_q <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < 2; c++) begin
        if (d_ptr[c] || d_clr[c]) begin
          ptr_q[c] <= 1'b0; // RL8 RL9
        end else if (d_tog[c]) begin
          ptr_q[c] <= !ptr_q[c]; // RL15
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    status_byte = {1'b0, raw_req[6], raw_req[5], 1'b0, // RL1 RL2
                   tc_q[7], tc_q[6], tc_q[5], 1'b0};
    rd_mux = 8'h00;
    if (io_addr_i == idc_pkg::OFS_HI_STATUS) begin
      rd_mux = status_byte;
    end
    for (int k = 0; k < 8; k++) begin
      if (idc_pkg::PAGE_MAP[k] && io_addr_i == idc_pkg::OFS_PAGE[k]) begin
        rd_mux = page_q[k];
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end else if (ce_i) begin
      rvalid_q <= rd_take;
      if (rd_take) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign io_wr_rdy_o  = wr_rdy_q;
  assign io_rd_rdy_o  = rd_rdy_q;
  assign io_rvalid_o  = rvalid_q;
  assign io_rdata_o   = rdata_q;
  assign svc_req_o    = svc_q;
  assign chan_mode_o  = mode_q;
  assign block_mode_o = block_q;
  assign cascade_o    = casc_q;
  assign addr_down_o  = down_q;
  assign page_o       = page_q;
  assign ext_timing_o = tim_q;
  assign byte_ptr_o   = ptr_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_mode_wr(int c, logic [1:0] m);
    pop && d_mode[c] && cmd.data[idc_pkg::XMODE_LSB +: 2] == m
      ##1 ce_i;
  endsequence

  a_status_bits: assert property (st_rd |=> // RL1
    io_rvalid_o && io_rdata_o[6:5] == $past(raw_req[6:5])
    && io_rdata_o[3:1] == $past(tc_q[7:5]))
    else $error("status request or count bits wrong");
  a_status_rsvd: assert property (st_rd |=> // RL2
    io_rdata_o[4] == 1'b0 && io_rdata_o[0] == 1'b0)
    else $error("status cascade bits not zero");
  a_req_write: assert property (pop && d_req[1] |=> // RL3
    sw_req_q[{1'b1, $past(cmd_sel)}] == $past(cmd_bit))
    else $error("request write not stored");
  a_mask_write: assert property (pop && d_mask[0] |=> // RL4
    mask_q[{1'b0, $past(cmd_sel)}] == $past(cmd_bit))
    else $error("single mask write not stored");
  a_mode_store: assert property (pop && d_mode[0] |=> // RL5
    mode_q[{1'b0, $past(cmd_sel)}] == $past(cmd.data[7:2]))
    else $error("mode fields not stored");
  a_block_mode: assert property (s_mode_wr(1, 2'h2) |=> // RL6
    block_mode_o[{1'b1, $past(cmd_sel, 2)}]
    && !cascade_o[{1'b1, $past(cmd_sel, 2)}])
    else $error("block mode not reported");
  a_casc_mode: assert property (s_mode_wr(0, 2'h3) |=> // RL6
    cascade_o[{1'b0, $past(cmd_sel, 2)}])
    else $error("cascade mode not reported");
  a_addr_dir: assert property (pop && d_mode[1] ##1 ce_i |=> // RL7
    addr_down_o[{1'b1, $past(cmd_sel, 2)}] == $past(cmd.data[5], 2))
    else $error("address direction wrong");
  a_ptr_clear: assert property (pop && d_ptr[0] |=> !byte_ptr_o[0]) // RL8
    else $error("byte pointer not cleared");
  a_full_reset: assert property (pop && d_clr[1] |=> // RL9
    mask_q[7:4] == 4'hF && sw_req_q[7:4] == 4'h0 && !byte_ptr_o[1])
    else $error("full reset incomplete");
  a_unmask_all: assert property (pop && d_unmask[0] |=> // RL10
    mask_q[3:0] == 4'h0)
    else $error("unmask all failed");
  a_all_mask: assert property (pop && d_allmask[1] |=> // RL11
    mask_q[7:4] == $past(cmd.data[3:0]))
    else $error("all mask load failed");
  a_mask_block: assert property (ce_i |=> // RL16
    (svc_req_o & $past(mask_q)) == 8'h00)
    else $error("masked channel requested service");
  a_page_write: assert property (d_page[5] |=> // RL12
    page_o[5] == $past(cmd.data))
    else $error("page write not stored");
  a_ext_store: assert property (pop && d_ext[0] |=> // RL14
    ext_timing_o[{1'b0, $past(cmd_sel)}] == $past(cmd.data[5:4]))
    else $error("extended timing not stored");
  a_ptr_toggle: assert property (d_tog[0] && !d_ptr[0] && !d_clr[0] // RL15
    |=> byte_ptr_o[0] != $past(byte_ptr_o[0]))
    else $error("byte pointer did not toggle");
  a_tc_clear: assert property (st_rd && tc_evt_i[7:5] == 3'h0 |=> // RL18
    tc_q[7:5] == 3'h0 && mask_q == $past(mask_q))
    else $error("status read side effects wrong");
endmodule : idc_top

// file: dv/idc_periph.sv
// peripheral and transfer engine model facing the dma control registers
`timescale 1ns/1ps
module idc_periph (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  // commands from the bench
  input  wire logic [7:0] req_lvl_i,
  input  wire logic [7:0] tc_cmd_i,
  // pins toward the block
  output logic      [7:0] dreq_pin_o = 8'h00,
  output logic      [7:0] tc_evt_o   = 8'h00
);
  // moves only off the sampling edge, so the block never races it
  always @(negedge core_clk_i) begin
    dreq_pin_o <= rst_n_i ? req_lvl_i : 8'h00;
    tc_evt_o   <= tc_cmd_i;
  end
endmodule : idc_periph

// file: dv/tb_top.sv
// self-checking bench for the dma channel control registers
`timescale 1ns/1ps
module tb_top;
  logic                     clk = 1'b0, rst_n = 1'b0, wr = 1'b0;
  logic                     rd = 1'b0, hold = 1'b0, wr_rdy, rd_rdy, rv;
  logic [15:0]              addr = 16'h0000;
  logic [7:0]               wd = 8'h00, req = 8'h00, tc = 8'h00;
  logic [7:0]               dreq, tce, rdat, svc, blk, casc, down, v;
  idc_pkg::idc_mode_s [7:0] mode;
  logic [7:0][7:0]          page;
  logic [7:0][1:0]          tim;
  logic [1:0]               bptr;
  int                       errors = 0, cmp_count = 0, n;

  always #12.5 clk = ~clk;
  idc_periph i_periph (.core_clk_i(clk), .rst_n_i(rst_n),
    .req_lvl_i(req), .tc_cmd_i(tc), .dreq_pin_o(dreq), .tc_evt_o(tce));
  // small depth so the refusal point is reached quickly
  idc_top #(.DEPTH(4)) i_dut (.core_clk_i(clk), .rst_n_i(rst_n),
    .ce_i(1'b1), .io_addr_i(addr), .io_wdata_i(wd), .io_wr_i(wr),
    .io_rd_i(rd), .io_wr_rdy_o(wr_rdy), .io_rd_rdy_o(rd_rdy),
    .io_rdata_o(rdat), .io_rvalid_o(rv), .dreq_pin_i(dreq),
    .tc_evt_i(tce), .cmd_hold_i(hold), .svc_req_o(svc),
    .chan_mode_o(mode), .block_mode_o(blk), .cascade_o(casc),
    .addr_down_o(down), .page_o(page), .ext_timing_o(tim),
    .byte_ptr_o(bptr));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] s, e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // 0 write ready, 1 read ready, 2 read answer
  task automatic wait_hi(input int w);
    int i;
    i = 0;
    while ((w == 0 ? wr_rdy : (w == 1 ? rd_rdy : rv)) !== 1'b1
           && i < 50) begin
      @(negedge clk);
      i++;
    end
    if (i >= 50) begin
      errors++;
      $display("unexpected wait %0d: expected 1 seen 0", w);
    end
  endtask : wait_hi
  // ready is registered, so its level at the falling edge holds
  // at the next rising edge where the request is taken
  task automatic wr_io(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wd = d;
    wr = 1'b1;
    wait_hi(0);
    @(negedge clk);
    wr = 1'b0;
    wait_hi(1);
    repeat (4) @(negedge clk);
  endtask : wr_io
  task automatic rd_io(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1'b1;
    wait_hi(1);
    @(negedge clk);
    rd = 1'b0;
    wait_hi(2);
    d = (rv === 1'b1) ? rdat : 8'hXX;
  endtask : rd_io

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_mask;
    chk("svc", svc, 8'h00);
    chk("page1", page[1], 8'h00);
    wr_io(16'h000E, 8'h00);
    wr_io(16'h00DC, 8'hFF);
    chk("svc", svc, 8'hEE);
    wr_io(16'h00D4, 8'h06);
    chk("svc", svc, 8'hAE);
    wr_io(16'h00D4, 8'h02);
    chk("svc", svc, 8'hEE);
    wr_io(16'h000F, 8'h05);
    chk("svc", svc, 8'hEA);
    wr_io(16'h000A, 8'h05);
    chk("svc", svc, 8'hE8);
    $display("test mask done");
  endtask : t_mask
  task automatic t_req;
    req <= 8'h00;
    wr_io(16'h000E, 8'h00);
    wr_io(16'h0009, 8'h06);
    chk("svc", svc, 8'h04);
    wr_io(16'h00D2, 8'h07);
    wr_io(16'h0009, 8'h02);
    chk("svc", svc, 8'h80);
    $display("test request done");
  endtask : t_req
  task automatic t_mode;
    wr_io(16'h00D6, 8'hB2);
    wr_io(16'h000B, 8'hC9);
    chk("mode6", {2'b00, mode[6]}, 8'h2C);
    chk("mode1", {2'b00, mode[1]}, 8'h32);
    chk("blk", {blk[6], blk[1]}, 8'h02);
    chk("casc", {casc[6], casc[1]}, 8'h01);
    chk("down", {down[6], down[1]}, 8'h02);
    $display("test mode done");
  endtask : t_mode
  task automatic t_status;
    req <= 8'h70;
    @(negedge clk);
    tc <= 8'hB0;
    @(negedge clk);
    tc <= 8'h00;
    repeat (4) @(negedge clk);
    rd_io(16'h00D0, v);
    chk("status", v, 8'h6A);
    rd_io(16'h00D0, v);
    chk("status", v, 8'h60);
    $display("test status done");
  endtask : t_status
  task automatic t_ptr;
    chk("bptr", bptr, 8'h00);
    rd_io(16'h00C0, v);
    rd_io(16'h0000, v);
    chk("bptr", bptr, 8'h03);
    wr_io(16'h00D8, 8'h5A);
    chk("bptr", bptr, 8'h01);
    wr_io(16'h000C, 8'hA5);
    chk("bptr", bptr, 8'h00);
    $display("test pointer done");
  endtask : t_ptr
  task automatic t_page;
    wr_io(16'h0083, 8'h5A);
    wr_io(16'h008B, 8'hC3);
    rd_io(16'h008B, v);
    chk("page5", v, 8'hC3);
    chk("page1", page[1], 8'h5A);
    rd_io(16'h0300, v);
    chk("unmapped", v, 8'h00);
    wr_io(16'h040B, 8'h32);
    wr_io(16'h04D6, 8'h23);
    chk("tim", {tim[7], tim[2]}, 8'h0B);
    $display("test page done");
  endtask : t_page
  task automatic t_clear;
    req <= 8'hEE;
    wr_io(16'h00DA, 8'h3C);
    chk("svc", svc, 8'h0E);
    chk("mode6", {2'b00, mode[6]}, 8'h00);
    chk("tim7", tim[7], 8'h00);
    chk("page1", page[1], 8'h5A);
    wr_io(16'h00DE, 8'h0A);
    chk("svc", svc, 8'h4E);
    $display("test clear done");
  endtask : t_clear
  task automatic t_fill;
    @(negedge clk);
    hold = 1'b1;
    addr = 16'h0081;
    wr = 1'b1;
    n = 0;
    repeat (8) begin
      wd = 8'h10 + n[7:0];
      if (wr_rdy === 1'b1) n++;
      @(negedge clk);
    end
    chk("refused", n[7:0], 8'h03);
    chk("rd_rdy", rd_rdy, 8'h00);
    hold = 1'b0;
    wait_hi(0);
    @(negedge clk);
    wr = 1'b0;
    repeat (12) @(negedge clk);
    chk("page2", page[2], 8'h13);
    $display("test fifo done");
  endtask : t_fill

  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  initial begin
    req <= 8'hEE;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_mask();
    t_req();
    t_mode();
    t_status();
    t_ptr();
    t_page();
    t_clear();
    t_fill();
    finish_test();
  end
  initial begin
    #200000;
    errors++;
    finish_test();
  end
endmodule : tb_top
